// file: rtl/ccp_chip_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_chip_config_regs #(
  parameter logic [15:0] PHY_ID_LOW  = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] PHY_ID_HIGH = 16'ha5a5  // Arbitrary value
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ccp_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [ccp_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          serial_mem_clock_strap,
  input  wire logic                          serial_mem_data_strap,
  input  wire logic                          port_led_bus_width_strap,
  input  wire logic                          shared_bus_strap,
  input  wire logic                          package_48pin_strap,
  input  wire ccp_pkg::ccp_phy_stat_type     phy_stat,
  output ccp_pkg::ccp_phy_ctrl_type          phy_ctrl,
  output ccp_pkg::ccp_cfg_type               chip_cfg
);

  function automatic ccp_pkg::ccp_rid_type decode(input logic [7:0] idx);
    logic [7:0] even;
    even = {idx[7:1], 1'b0};
    if (idx <= ccp_pkg::IDX_RESV_LAST) begin
      return ccp_pkg::RID_RESV;
    end
    unique case (even)
      ccp_pkg::IDX_CFG:     return ccp_pkg::RID_CFG;
      ccp_pkg::IDX_BCTL:    return ccp_pkg::RID_BCTL;
      ccp_pkg::IDX_BSTAT:   return ccp_pkg::RID_BSTAT;
      ccp_pkg::IDX_ID_LO:   return ccp_pkg::RID_ID_LO;
      ccp_pkg::IDX_ID_HI:   return ccp_pkg::RID_ID_HI;
      ccp_pkg::IDX_ADV:     return ccp_pkg::RID_ADV;
      ccp_pkg::IDX_PARTNER: return ccp_pkg::RID_PARTNER;
      ccp_pkg::IDX_SPECIAL: return ccp_pkg::RID_SPECIAL;
      ccp_pkg::IDX_PCTL:    return ccp_pkg::RID_PCTL;
      ccp_pkg::IDX_PSTAT:   return ccp_pkg::RID_PSTAT;
      default: begin
        // Lower map lives elsewhere; upper reserved words answer okay
        if (idx >= ccp_pkg::IDX_UPPER_FIRST) begin
          return ccp_pkg::RID_RESV;
        end
        return ccp_pkg::RID_NONE;
      end
    endcase
  endfunction : decode

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // Strap synchronisers and capture
  logic [4:0]           strap_s1_ff;
  logic [4:0]           strap_s2_ff;
  logic [4:0]           strap_s3_ff;
  logic [1:0]           settle_cnt_ff;
  logic                 cfg_valid_ff;
  ccp_pkg::ccp_cfg_type cfg_ff;
  logic                 capture;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_ff <= 5'h00;
      strap_s2_ff <= 5'h00;
      strap_s3_ff <= 5'h00;
    end else begin
      strap_s1_ff <= {package_48pin_strap, shared_bus_strap, port_led_bus_width_strap,
                      serial_mem_data_strap, serial_mem_clock_strap};
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
    end
  end

  // Wait for the pipeline to fill and agree, so a bouncing strap is not caught
  assign capture = !cfg_valid_ff && settle_cnt_ff == ccp_pkg::STRAP_SETTLE
                   && strap_s2_ff == strap_s3_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_ff <= 2'd0;
    end else if (settle_cnt_ff != ccp_pkg::STRAP_SETTLE) begin
      settle_cnt_ff <= settle_cnt_ff + 2'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_valid_ff <= 1'b0;
      cfg_ff       <= '0;
    end else if (capture) begin
      cfg_valid_ff  <= 1'b1;
      cfg_ff.endian <= strap_s3_ff[0];
      cfg_ff.eeprom <= strap_s3_ff[1];
      cfg_ff.bus8   <= strap_s3_ff[2];
      cfg_ff.bus16  <= !strap_s3_ff[2];
      cfg_ff.shared <= strap_s3_ff[3];
      cfg_ff.pkg48  <= strap_s3_ff[4];
    end
  end

  logic [15:0] cfg_word;
  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[ccp_pkg::CFG_ENDIAN_BIT] = cfg_ff.endian;
    cfg_word[ccp_pkg::CFG_EEPROM_BIT] = cfg_ff.eeprom;
    cfg_word[ccp_pkg::CFG_BUS8_BIT]   = cfg_ff.bus8;
    cfg_word[ccp_pkg::CFG_BUS16_BIT]  = cfg_ff.bus16;
    cfg_word[ccp_pkg::CFG_SHARED_BIT] = cfg_ff.shared;
    cfg_word[ccp_pkg::CFG_PKG48_BIT]  = cfg_ff.pkg48;
  end

  // Write channel; bus stays closed until straps are captured
  logic                        awready_ff;
  logic                        wready_ff;
  logic                        bvalid_ff;
  logic [1:0]                  bresp_ff;
  logic [7:0]                  wr_idx_ff;
  logic [15:0]                 wr_raw_ff;
  logic [1:0]                  wr_strb_ff;
  logic                        do_write;
  ccp_pkg::ccp_rid_type        wr_rid;
  logic [15:0]                 wr_data;
  logic [1:0]                  wr_be;

  assign do_write = cfg_valid_ff && !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_rid   = decode(wr_idx_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else if (capture || do_write) begin
      awready_ff <= 1'b1;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      wr_idx_ff  <= awaddr[9:2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff  <= 1'b0;
      wr_raw_ff  <= 16'h0000;
      wr_strb_ff <= 2'b00;
    end else if (capture || do_write) begin
      wready_ff <= 1'b1;
    end else if (wvalid && wready_ff) begin
      wready_ff  <= 1'b0;
      wr_raw_ff  <= wdata[15:0];
      wr_strb_ff <= wstrb[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= ccp_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_rid == ccp_pkg::RID_NONE) ? ccp_pkg::RESP_SLVERR : ccp_pkg::RESP_OKAY;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Byte lane steering: odd index is the high byte in either width
  always_comb begin
    wr_data = 16'h0000;
    wr_be   = 2'b00;
    if (wr_idx_ff[0]) begin
      wr_data = {wr_raw_ff[7:0], 8'h00};
      wr_be   = {wr_strb_ff[0], 1'b0};
    end else if (cfg_ff.bus8) begin
      wr_data = {8'h00, wr_raw_ff[7:0]};
      wr_be   = {1'b0, wr_strb_ff[0]};
    end else begin
      wr_data = wr_raw_ff;
      wr_be   = wr_strb_ff;
    end
  end

  // Register storage: host-writable, plus the PHY-reported partner and port status
  logic [15:0] bctl_ff;
  logic [15:0] adv_ff;
  logic [15:0] special_ff;
  logic [15:0] pctl_ff;
  logic [15:0] nxt_special;
  logic [15:0] bstat_ff;
  logic [15:0] partner_ff;
  logic [15:0] pstat_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bctl_ff <= ccp_pkg::RST_BCTL;
      adv_ff  <= ccp_pkg::RST_ADV;
      pctl_ff <= ccp_pkg::RST_PCTL;
    end else if (do_write) begin
      if (wr_rid == ccp_pkg::RID_BCTL) begin
        bctl_ff <= merge(bctl_ff, wr_data, wr_be);
      end
      if (wr_rid == ccp_pkg::RID_ADV) begin
        adv_ff <= merge(adv_ff, wr_data, wr_be);
      end
      if (wr_rid == ccp_pkg::RID_PCTL) begin
        pctl_ff <= merge(pctl_ff, wr_data, wr_be);
      end
    end
  end

  // Diagnostic-done flag: an event in the clearing cycle wins
  always_comb begin
    nxt_special = special_ff;
    if (do_write && wr_rid == ccp_pkg::RID_SPECIAL) begin
      nxt_special = merge(special_ff, wr_data, wr_be);
      nxt_special[ccp_pkg::SPECIAL_W1C_BIT] = special_ff[ccp_pkg::SPECIAL_W1C_BIT]
        && !(wr_be[0] && wr_data[ccp_pkg::SPECIAL_W1C_BIT]);
    end
    if (phy_stat.diag_done_event) begin
      nxt_special[ccp_pkg::SPECIAL_W1C_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      special_ff <= ccp_pkg::RST_SPECIAL;
    end else begin
      special_ff <= nxt_special;
    end
  end

  // Jabber flag clears on any write to its byte, whatever the data, unless a jabber event arrives in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bstat_ff <= ccp_pkg::RST_BSTAT;
    end else if (phy_stat.jabber_event) begin
      bstat_ff[ccp_pkg::BSTAT_WAC_BIT] <= 1'b1;
    end else if (do_write && wr_rid == ccp_pkg::RID_BSTAT && wr_be[0]) begin
      bstat_ff[ccp_pkg::BSTAT_WAC_BIT] <= 1'b0;
    end
  end

  // Values the PHY reports; host writes never touch them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      partner_ff <= ccp_pkg::RST_PARTNER;
      pstat_ff   <= ccp_pkg::RST_PSTAT;
    end else if (phy_stat.load) begin
      partner_ff <= phy_stat.partner_ability;
      pstat_ff   <= phy_stat.port_status;
    end
  end

  // Read channel
  logic                 arready_ff;
  logic                 rvalid_ff;
  logic [31:0]          rdata_ff;
  logic [1:0]           rresp_ff;
  logic [7:0]           rd_idx;
  ccp_pkg::ccp_rid_type rd_rid;
  logic [15:0]          rd_word;
  logic [31:0]          rd_view;

  assign rd_idx = araddr[9:2];
  assign rd_rid = decode(rd_idx);

  always_comb begin
    unique case (rd_rid)
      ccp_pkg::RID_CFG:     rd_word = cfg_word;
      ccp_pkg::RID_BCTL:    rd_word = bctl_ff;
      ccp_pkg::RID_BSTAT:   rd_word = bstat_ff;
      ccp_pkg::RID_ID_LO:   rd_word = PHY_ID_LOW;
      ccp_pkg::RID_ID_HI:   rd_word = PHY_ID_HIGH;
      ccp_pkg::RID_ADV:     rd_word = adv_ff;
      ccp_pkg::RID_PARTNER: rd_word = partner_ff;
      ccp_pkg::RID_SPECIAL: rd_word = special_ff;
      ccp_pkg::RID_PCTL:    rd_word = pctl_ff;
      ccp_pkg::RID_PSTAT:   rd_word = pstat_ff;
      default:              rd_word = 16'h0000;
    endcase
    if (rd_idx[0]) begin
      rd_view = {24'h000000, rd_word[15:8]};
    end else if (cfg_ff.bus8) begin
      rd_view = {24'h000000, rd_word[7:0]};
    end else begin
      rd_view = {16'h0000, rd_word};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= ccp_pkg::RESP_OKAY;
    end else if (capture) begin
      arready_ff <= 1'b1;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_view;
      rresp_ff   <= (rd_rid == ccp_pkg::RID_NONE) ? ccp_pkg::RESP_SLVERR
                                                  : ccp_pkg::RESP_OKAY;
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign awready  = awready_ff;
  assign wready   = wready_ff;
  assign bvalid   = bvalid_ff;
  assign bresp    = bresp_ff;
  assign arready  = arready_ff;
  assign rvalid   = rvalid_ff;
  assign rdata    = rdata_ff;
  assign rresp    = rresp_ff;
  assign chip_cfg = cfg_ff;
  assign phy_ctrl = '{basic_control: bctl_ff, advertise: adv_ff,
                      special: special_ff, port_control: pctl_ff};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cfg_frozen;
    cfg_valid_ff && $past(cfg_valid_ff) |-> $stable(cfg_ff);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed");

  property p_endian_capture;
    $rose(cfg_valid_ff) |-> cfg_ff.endian == $past(strap_s3_ff[0]);
  endproperty
  a_endian_capture: assert property (p_endian_capture) else $error("endian bad");

  property p_eeprom_capture;
    $rose(cfg_valid_ff) |-> cfg_ff.eeprom == $past(strap_s3_ff[1])
                            && cfg_ff.pkg48 == $past(strap_s3_ff[4]);
  endproperty
  a_eeprom_capture: assert property (p_eeprom_capture) else $error("strap bad");

  property p_width_onehot;
    cfg_valid_ff |-> cfg_ff.bus8 != cfg_ff.bus16;
  endproperty
  a_width_onehot: assert property (p_width_onehot) else $error("width bits");

  property p_w1c;
    do_write && wr_rid == ccp_pkg::RID_SPECIAL && wr_be[0] && wr_data[0]
      && !phy_stat.diag_done_event |=> !special_ff[ccp_pkg::SPECIAL_W1C_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c not cleared");

  property p_wac;
    do_write && wr_rid == ccp_pkg::RID_BSTAT && wr_be[0] && !phy_stat.jabber_event
      |=> !bstat_ff[ccp_pkg::BSTAT_WAC_BIT] && $stable(bstat_ff[15:2]);
  endproperty
  a_wac: assert property (p_wac) else $error("wac not cleared");

  property p_rw_adv;
    do_write && wr_rid == ccp_pkg::RID_ADV && wr_be == 2'b11 |=> adv_ff == $past(wr_data);
  endproperty
  a_rw_adv: assert property (p_rw_adv) else $error("rw lost");

  property p_resv_zero;
    arvalid && arready_ff && rd_idx <= ccp_pkg::IDX_RESV_LAST
      |=> rvalid_ff && rdata_ff == 32'h00000000 && rresp_ff == ccp_pkg::RESP_OKAY;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved read");

  property p_odd_high;
    arvalid && arready_ff && rd_idx == 8'he5 |=> rdata_ff == {24'h000000, $past(bctl_ff[15:8])};
  endproperty
  a_odd_high: assert property (p_odd_high) else $error("odd byte");

  property p_reset_vals;
    @(posedge aclk) disable iff (1'b0)
      !aresetn |=> bctl_ff == ccp_pkg::RST_BCTL && bstat_ff == ccp_pkg::RST_BSTAT
        && adv_ff == ccp_pkg::RST_ADV && partner_ff == ccp_pkg::RST_PARTNER
        && special_ff == ccp_pkg::RST_SPECIAL && pctl_ff == ccp_pkg::RST_PCTL
        && pstat_ff == ccp_pkg::RST_PSTAT;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value");

  property p_cfg_write_ignored;
    do_write && wr_rid == ccp_pkg::RID_CFG |=> bvalid_ff ##0 $stable(cfg_word);
  endproperty
  a_cfg_write_ignored: assert property (p_cfg_write_ignored) else $error("cfg written");

  c_write_done: cover property (do_write ##1 bvalid_ff && bready);
  c_read_8bit:  cover property (cfg_ff.bus8 && arvalid && arready_ff ##1 rvalid_ff);
  c_w1c_race:   cover property (do_write && wr_rid == ccp_pkg::RID_SPECIAL
                                && phy_stat.diag_done_event);

endmodule : ccp_chip_config_regs
`default_nettype wire

// file: rtl/ccp_pkg.sv
package ccp_pkg;

  localparam int unsigned ADDR_W = 10;

  // Printed offsets are register indices; byte address is index times four
  localparam logic [7:0] IDX_RESV_LAST   = 8'h07;
  localparam logic [7:0] IDX_CFG         = 8'h08;
  localparam logic [7:0] IDX_UPPER_FIRST = 8'he0;
  localparam logic [7:0] IDX_BCTL        = 8'he4;
  localparam logic [7:0] IDX_BSTAT       = 8'he6;
  localparam logic [7:0] IDX_ID_LO       = 8'he8;
  localparam logic [7:0] IDX_ID_HI       = 8'hea;
  localparam logic [7:0] IDX_ADV         = 8'hec;
  localparam logic [7:0] IDX_PARTNER     = 8'hee;
  localparam logic [7:0] IDX_SPECIAL     = 8'hf4;
  localparam logic [7:0] IDX_PCTL        = 8'hf6;
  localparam logic [7:0] IDX_PSTAT       = 8'hf8;

  localparam logic [15:0] RST_BCTL    = 16'h3120;
  localparam logic [15:0] RST_BSTAT   = 16'h7808;
  localparam logic [15:0] RST_ADV     = 16'h05e1;
  localparam logic [15:0] RST_PARTNER = 16'h0001;
  localparam logic [15:0] RST_SPECIAL = 16'h0000;
  localparam logic [15:0] RST_PCTL    = 16'h00ff;
  localparam logic [15:0] RST_PSTAT   = 16'h8080;

  // Configuration field positions
  localparam int unsigned CFG_ENDIAN_BIT = 10;
  localparam int unsigned CFG_EEPROM_BIT = 9;
  localparam int unsigned CFG_BUS8_BIT   = 7;
  localparam int unsigned CFG_BUS16_BIT  = 6;
  localparam int unsigned CFG_SHARED_BIT = 4;
  localparam int unsigned CFG_PKG48_BIT  = 1;

  // Sticky event flags
  localparam int unsigned BSTAT_WAC_BIT   = 1;
  localparam int unsigned SPECIAL_W1C_BIT = 0;

  // Cycles after reset release before straps are sampled
  localparam logic [1:0] STRAP_SETTLE = 2'd3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    RID_NONE, RID_RESV, RID_CFG, RID_BCTL, RID_BSTAT, RID_ID_LO, RID_ID_HI,
    RID_ADV, RID_PARTNER, RID_SPECIAL, RID_PCTL, RID_PSTAT
  } ccp_rid_type;

  typedef struct packed {
    logic endian;
    logic eeprom;
    logic bus8;
    logic bus16;
    logic shared;
    logic pkg48;
  } ccp_cfg_type;

  typedef struct packed {
    logic [15:0] basic_control;
    logic [15:0] advertise;
    logic [15:0] special;
    logic [15:0] port_control;
  } ccp_phy_ctrl_type;

  typedef struct packed {
    logic [15:0] partner_ability;
    logic [15:0] port_status;
    logic        load;
    logic        jabber_event;
    logic        diag_done_event;
  } ccp_phy_stat_type;

endpackage : ccp_pkg

// file: verif/ccp_chip_config_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_chip_config_regs_tb;
  localparam logic [15:0] ID_LO = 16'h1b2c; // Arbitrary value
  localparam logic [15:0] ID_HI = 16'h3d4e; // Arbitrary value
  logic                       aclk;
  logic                       aresetn;
  logic [ccp_pkg::ADDR_W-1:0] awaddr;
  logic                       awvalid;
  logic                       awready;
  logic [31:0]                wdata;
  logic [3:0]                 wstrb;
  logic                       wvalid;
  logic                       wready;
  logic [1:0]                 bresp;
  logic                       bvalid;
  logic                       bready;
  logic [ccp_pkg::ADDR_W-1:0] araddr;
  logic                       arvalid;
  logic                       arready;
  logic [31:0]                rdata;
  logic [1:0]                 rresp;
  logic                       rvalid;
  logic                       rready;
  logic [4:0]                 straps;
  ccp_pkg::ccp_phy_stat_type  phy_stat;
  ccp_pkg::ccp_phy_ctrl_type  phy_ctrl;
  ccp_pkg::ccp_cfg_type       chip_cfg;
  int                         n_mismatch;
  int                         num_checks;
  logic [15:0]                mdl [3];
  logic [7:0]                 rwi [3];
  logic [7:0]                 ri  [9];
  logic [15:0]                rv  [9];

  ccp_chip_config_regs #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_mem_clock_strap(straps[4]), .serial_mem_data_strap(straps[3]),
    .port_led_bus_width_strap(straps[2]), .shared_bus_strap(straps[1]),
    .package_48pin_strap(straps[0]), .phy_stat(phy_stat), .phy_ctrl(phy_ctrl),
    .chip_cfg(chip_cfg));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Wide enough for the whole control struct, not just its lower half
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Strap word as the configuration register should show it
  function automatic logic [15:0] cfg_word(input logic [4:0] st);
    return {5'h00, st[4], st[3], 1'b0, st[2], ~st[2], 1'b0, st[1], 2'b00, st[0], 1'b0};
  endfunction : cfg_word

  // Lane placement of a word for an even or odd index
  function automatic logic [31:0] view(input logic [15:0] w, input logic odd, input logic b8);
    if (odd) return {24'h0, w[15:8]};
    if (b8) return {24'h0, w[7:0]};
    return {16'h0, w};
  endfunction : view

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
                                        input logic [1:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge

  // Entry waits one edge so strobes are never reassigned in the same step
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] s,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {16'($urandom), d};
    wstrb   <= {2'b00, s};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 50);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    chk("write_done", 32'h1, {31'h0, bvalid});
    bready <= 1'b0;
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 50);
    chk(what, exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("read_done", 32'h1, {31'h0, rvalid});
    rready <= 1'b0;
  endtask : rdc

  task automatic do_reset(input logic [4:0] st);
    @(posedge aclk);
    aresetn <= 1'b0;
    straps  <= st;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{ccp_pkg::RST_BCTL, ccp_pkg::RST_ADV, ccp_pkg::RST_PCTL};
  endtask : do_reset

  task automatic pulse_stat(input logic [2:0] which);
    @(posedge aclk);
    {phy_stat.load, phy_stat.jabber_event, phy_stat.diag_done_event} <= which;
    @(posedge aclk);
    {phy_stat.load, phy_stat.jabber_event, phy_stat.diag_done_event} <= 3'b000;
  endtask : pulse_stat

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [4:0]  st;
    logic [15:0] d;
    logic [15:0] pa;
    logic [15:0] ps;
    logic [1:0]  s;
    int          k;
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, straps} = '0;
    phy_stat = '0;
    n_mismatch = 0;
    num_checks = 0;
    rwi = '{ccp_pkg::IDX_BCTL, ccp_pkg::IDX_ADV, ccp_pkg::IDX_PCTL};
    ri = '{ccp_pkg::IDX_BCTL, ccp_pkg::IDX_BSTAT, ccp_pkg::IDX_ID_LO, ccp_pkg::IDX_ID_HI,
           ccp_pkg::IDX_ADV, ccp_pkg::IDX_PARTNER, ccp_pkg::IDX_SPECIAL, ccp_pkg::IDX_PCTL,
           ccp_pkg::IDX_PSTAT};
    rv = '{16'h3120, 16'h7808, ID_LO, ID_HI, 16'h05e1, 16'h0001, 16'h0000, 16'h00ff,
           16'h8080};
    void'($urandom(43));
    // 16-bit bus mode first
    st = 5'($urandom) & 5'b11011;
    do_reset(st);
    d = cfg_word(st);
    rdc("cfg", ccp_pkg::IDX_CFG, {16'h0, d}, 2'b00);
    rdc("cfg_hi", 8'h09, {24'h0, d[15:8]}, 2'b00);
    chk("chip_cfg", {26'h0, st[4:2], ~st[2], st[1:0]}, {26'h0, chip_cfg});
    wr(ccp_pkg::IDX_CFG, ~d, 2'b11, 2'b00);
    rdc("cfg_ro", ccp_pkg::IDX_CFG, {16'h0, d}, 2'b00);
    for (k = 0; k < 9; k++) rdc("reset_val", ri[k], {16'h0, rv[k]}, 2'b00);
    chk("phy_ctrl", {16'h3120, 16'h05e1, 16'h0000, 16'h00ff}, phy_ctrl);
    foreach (ri[k]) begin
      if (k == 2 || k == 3 || k == 5 || k == 8) begin
        wr(ri[k], ~rv[k], 2'b11, 2'b00);
        rdc("read_only", ri[k], {16'h0, rv[k]}, 2'b00);
      end
    end
    for (k = 0; k < 8; k++) begin
      wr(k[7:0], 16'($urandom), 2'b11, 2'b00);
      rdc("reserved", k[7:0], 32'h0, 2'b00);
    end
    rdc("lower_map", 8'h10, 32'h0, 2'b10);
    // Full-word write, so the both-lanes path is always exercised
    d = 16'($urandom);
    wr(ccp_pkg::IDX_ADV, d, 2'b11, 2'b00);
    mdl[1] = d;
    rdc("adv_full", ccp_pkg::IDX_ADV, {16'h0, d}, 2'b00);
    // Random writes with random lanes, lane-less writes included
    repeat (16) begin
      k = $urandom_range(2);
      d = 16'($urandom);
      s = 2'($urandom);
      wr(rwi[k], d, s, 2'b00);
      mdl[k] = merge(mdl[k], d, s);
      rdc("rw_reg", rwi[k], {16'h0, mdl[k]}, 2'b00);
      chk("phy_ctrl", {mdl[0], mdl[1], 16'h0000, mdl[2]}, phy_ctrl);
    end
    pulse_stat(3'b010);
    rdc("bstat_set", ccp_pkg::IDX_BSTAT, 32'h780a, 2'b00);
    wr(ccp_pkg::IDX_BSTAT, 16'($urandom), 2'b01, 2'b00);
    rdc("bstat_clr", ccp_pkg::IDX_BSTAT, 32'h7808, 2'b00);
    pulse_stat(3'b001);
    wr(ccp_pkg::IDX_SPECIAL, 16'hc3c2, 2'b11, 2'b00);
    rdc("special_keep", ccp_pkg::IDX_SPECIAL, 32'hc3c3, 2'b00);
    wr(ccp_pkg::IDX_SPECIAL, 16'h0001, 2'b11, 2'b00);
    rdc("special_clr", ccp_pkg::IDX_SPECIAL, 32'h0, 2'b00);
    pa = 16'($urandom);
    ps = 16'($urandom);
    @(posedge aclk);
    phy_stat.partner_ability <= pa;
    phy_stat.port_status     <= ps;
    pulse_stat(3'b100);
    rdc("partner", ccp_pkg::IDX_PARTNER, {16'h0, pa}, 2'b00);
    rdc("pstat", ccp_pkg::IDX_PSTAT, {16'h0, ps}, 2'b00);
    // Mid-run reset into 8-bit bus mode
    st = 5'($urandom) | 5'b00100;
    do_reset(st);
    d = cfg_word(st);
    rdc("cfg8", ccp_pkg::IDX_CFG, {24'h0, d[7:0]}, 2'b00);
    chk("chip_cfg8", {26'h0, st[4:2], ~st[2], st[1:0]}, {26'h0, chip_cfg});
    for (k = 0; k < 9; k++) begin
      rdc("lo_byte", ri[k], view(rv[k], 1'b0, 1'b1), 2'b00);
      rdc("hi_byte", ri[k] + 8'h01, view(rv[k], 1'b1, 1'b1), 2'b00);
    end
    wr(ccp_pkg::IDX_BCTL + 8'h01, 16'h00ab, 2'b01, 2'b00);
    wr(ccp_pkg::IDX_BCTL, 16'h005c, 2'b01, 2'b00);
    chk("bctl8", 32'h0000ab5c, {16'h0, phy_ctrl.basic_control});
    rdc("bctl8_lo", ccp_pkg::IDX_BCTL, 32'h5c, 2'b00);
    rdc("bctl8_hi", ccp_pkg::IDX_BCTL + 8'h01, 32'hab, 2'b00);
    end_sim();
  end
endmodule : ccp_chip_config_regs_tb
`default_nettype wire
